//--- src/gpp_pkg.sv
// constants, field layouts and carriers for the 32-pin general purpose port
// How it works
// - drive level register, one bit per pin
// - level-set alias sets bits written one
// - level-clear alias clears bits written one
// - level aliases read back drive level register
// - direction register, zero input, one output
// - direction-set alias makes written pins outputs
// - direction aliases read back direction register
// - sampled level reports pin inputs when connected
// - direction bit shared with line config
package gpp_pkg;

    localparam int          GPP_PINS          = 32;
    localparam int          GPP_ADDR_W        = 12;
    localparam int          GPP_DATA_W        = 32;

    // register byte offsets
    localparam logic [11:0] OFS_DRIVE_LEVEL   = 12'h504;
    localparam logic [11:0] OFS_DRIVE_SET     = 12'h508;
    localparam logic [11:0] OFS_DRIVE_CLEAR   = 12'h50C;
    localparam logic [11:0] OFS_SAMPLED_LEVEL = 12'h510;
    localparam logic [11:0] OFS_ORIENT        = 12'h514;
    localparam logic [11:0] OFS_ORIENT_SET    = 12'h518;
    localparam logic [11:0] OFS_ORIENT_CLEAR  = 12'h51C;
    localparam logic [11:0] OFS_LINE_CFG_BASE = 12'h700;
    localparam logic [11:0] OFS_LINE_CFG_LAST = 12'h77C;

    // values after reset
    localparam logic [31:0] RST_DRIVE_LEVEL   = 32'h0000_0000;
    localparam logic [31:0] RST_ORIENT        = 32'h0000_0000;
    localparam logic [31:0] RST_LINE_CFG      = 32'h0000_0002;
    localparam logic [31:0] RST_RDATA         = 32'h0000_0000;

    // line config field positions
    localparam int          POS_DIR           = 0;
    localparam int          POS_INPUT         = 1;
    localparam int          POS_PULL          = 2;
    localparam int          POS_DRIVE         = 8;
    localparam int          POS_SENSE         = 16;

    // pull encodings
    localparam logic [1:0]  PULL_DOWN         = 2'h1;
    localparam logic [1:0]  PULL_UP           = 2'h3;

    typedef struct packed {
        logic [1:0] sense;
        logic [2:0] drive;
        logic [1:0] pull;
        logic       input_off;
    } gpp_line_cfg_s;

    localparam gpp_line_cfg_s RST_LINE_FIELDS = '{sense: 2'h0, drive: 3'h0,
                                                  pull: 2'h0, input_off: 1'b1};

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } gpp_bus_req_s;

    // build a line config word from the shared direction bit and the fields
    function automatic logic [31:0] gpp_cfg_pack(input logic dir, input gpp_line_cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[POS_DIR] = dir;
        w[POS_INPUT] = c.input_off;
        w[POS_PULL +: 2] = c.pull;
        w[POS_DRIVE +: 3] = c.drive;
        w[POS_SENSE +: 2] = c.sense;
        return w;
    endfunction : gpp_cfg_pack

    // take the stored fields out of a written line config word
    function automatic gpp_line_cfg_s gpp_cfg_unpack(input logic [31:0] w);
        gpp_line_cfg_s c;
        c.input_off = w[POS_INPUT];
        c.pull = w[POS_PULL +: 2];
        c.drive = w[POS_DRIVE +: 3];
        c.sense = w[POS_SENSE +: 2];
        return c;
    endfunction : gpp_cfg_unpack

    // true when an address falls in the line config window
    function automatic logic gpp_is_line_cfg(input logic [11:0] a);
        return (a >= OFS_LINE_CFG_BASE) && (a <= OFS_LINE_CFG_LAST) && (a[1:0] == 2'h0);
    endfunction : gpp_is_line_cfg

endpackage : gpp_pkg

//--- src/gpp_in_sync.sv
// two-stage synchroniser for the pin inputs with input buffer gating
`timescale 1ns/1ns
`default_nettype none
module gpp_in_sync
    import gpp_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic [GPP_PINS-1:0] pad_in_i,
    input  wire logic [GPP_PINS-1:0] buf_on_i,
    output logic      [GPP_PINS-1:0] level_o
);

    logic [GPP_PINS-1:0] meta;
    logic [GPP_PINS-1:0] stable;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta   <= '0;
            stable <= '0;
        end else begin
            meta   <= pad_in_i;
            stable <= meta;
        end
    end

    // a disconnected buffer reads low, its pin value is not valid
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_o <= '0;
        end else begin
            level_o <= stable & buf_on_i;
        end
    end

endmodule : gpp_in_sync
`default_nettype wire

//--- src/gpp_pin_drive.sv
// per-pin output driver: level, enable, strength and pulls from flip-flops
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_drive
    import gpp_pkg::*;
(
    input  wire logic                               clk_i,
    input  wire logic                               reset_n_i,
    input  wire logic          [GPP_PINS-1:0]       level_i,
    input  wire logic          [GPP_PINS-1:0]       dir_i,
    input  wire gpp_line_cfg_s [GPP_PINS-1:0]       cfg_i,
    output logic               [GPP_PINS-1:0]       pad_out_o,
    output logic               [GPP_PINS-1:0]       pad_oe_o,
    output logic               [GPP_PINS-1:0]       pad_hi_drive_o,
    output logic               [GPP_PINS-1:0]       pull_up_o,
    output logic               [GPP_PINS-1:0]       pull_down_o
);

    logic [GPP_PINS-1:0] next_oe;
    logic [GPP_PINS-1:0] next_hi;

    // drive modes 4..7 float one of the levels for wired-or and wired-and
    always_comb begin
        for (int i = 0; i < GPP_PINS; i++) begin
            logic [2:0] m;
            m = cfg_i[i].drive;
            if (level_i[i]) begin
                next_oe[i] = dir_i[i] && (m != 3'h6) && (m != 3'h7);
                next_hi[i] = (m == 3'h2) || (m == 3'h3) || (m == 3'h5);
            end else begin
                next_oe[i] = dir_i[i] && (m != 3'h4) && (m != 3'h5);
                next_hi[i] = (m == 3'h1) || (m == 3'h3) || (m == 3'h7);
            end
        end
    end

    // registered so the pads never see a decode glitch
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_out_o      <= '0;
            pad_oe_o       <= '0;
            pad_hi_drive_o <= '0;
            pull_up_o      <= '0;
            pull_down_o    <= '0;
        end else begin
            pad_out_o      <= level_i;
            pad_oe_o       <= next_oe;
            pad_hi_drive_o <= next_hi & next_oe;
            for (int i = 0; i < GPP_PINS; i++) begin
                pull_up_o[i]   <= (cfg_i[i].pull == PULL_UP);
                pull_down_o[i] <= (cfg_i[i].pull == PULL_DOWN);
            end
        end
    end

endmodule : gpp_pin_drive
`default_nettype wire

//--- src/gpp_port.sv
// top of the general purpose port: register slave, storage and pin wiring
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module gpp_port
    import gpp_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    // register port
    input  wire logic [GPP_ADDR_W-1:0] addr_i,
    input  wire logic [GPP_DATA_W-1:0] wdata_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    output logic      [GPP_DATA_W-1:0] rdata_o,
    // pins
    input  wire logic [GPP_PINS-1:0]   pad_in_i,
    output logic      [GPP_PINS-1:0]   pad_out_o,
    output logic      [GPP_PINS-1:0]   pad_oe_o,
    output logic      [GPP_PINS-1:0]   pad_hi_drive_o,
    output logic      [GPP_PINS-1:0]   pull_up_o,
    output logic      [GPP_PINS-1:0]   pull_down_o
);

    gpp_bus_req_s                   req;
    logic          [GPP_PINS-1:0]   drive_level_reg;
    logic          [GPP_PINS-1:0]   orientation_reg;
    gpp_line_cfg_s [GPP_PINS-1:0]   line_config;
    logic          [GPP_PINS-1:0]   sampled_level;
    logic          [GPP_PINS-1:0]   buf_on;
    logic                           wr_level;
    logic                           wr_level_set;
    logic                           wr_level_clear;
    logic                           wr_orient;
    logic                           wr_orient_set;
    logic                           wr_orient_clear;
    logic                           wr_line;
    logic          [4:0]            line_idx;
    logic          [GPP_DATA_W-1:0] next_rdata;

    // bundle the bus port so the decode reads one carrier
    assign req = '{addr: addr_i, wdata: wdata_i, we: we_i, re: re_i};

    // line config word n sits at base plus four times n
    assign line_idx = 5'((req.addr - OFS_LINE_CFG_BASE) >> 2);

    // write decode, one strobe per register, one shared by the whole line config window
    always_comb begin
        wr_level        = req.we && (req.addr == OFS_DRIVE_LEVEL);
        wr_level_set    = req.we && (req.addr == OFS_DRIVE_SET);
        wr_level_clear  = req.we && (req.addr == OFS_DRIVE_CLEAR);
        wr_orient       = req.we && (req.addr == OFS_ORIENT);
        wr_orient_set   = req.we && (req.addr == OFS_ORIENT_SET);
        wr_orient_clear = req.we && (req.addr == OFS_ORIENT_CLEAR);
        wr_line         = req.we && gpp_is_line_cfg(req.addr);
    end

    // drive level: plain write, or bitwise set and clear with no
    // read-modify-write race between software threads
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drive_level_reg <= RST_DRIVE_LEVEL;
        end else if (wr_level) begin
            drive_level_reg <= req.wdata;
        end else if (wr_level_set) begin
            drive_level_reg <= drive_level_reg | req.wdata;
        end else if (wr_level_clear) begin
            drive_level_reg <= drive_level_reg & ~req.wdata;
        end
    end

    // direction: one flip-flop per pin, reached from the direction
    // register, its two aliases and bit 0 of the pin's line config
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            orientation_reg <= RST_ORIENT;
        end else if (wr_orient) begin
            orientation_reg <= req.wdata;
        end else if (wr_orient_set) begin
            orientation_reg <= orientation_reg | req.wdata;
        end else if (wr_orient_clear) begin
            orientation_reg <= orientation_reg & ~req.wdata;
        end else if (wr_line) begin
            orientation_reg[line_idx] <= req.wdata[POS_DIR];
        end
    end

    // remaining line config fields; reset leaves input buffers off
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < GPP_PINS; i++) begin
                line_config[i] <= RST_LINE_FIELDS;
            end
        end else if (wr_line) begin
            line_config[line_idx] <= gpp_cfg_unpack(req.wdata);
        end
    end

    // input buffer connected when its disconnect bit is low
    always_comb begin
        for (int i = 0; i < GPP_PINS; i++) begin
            buf_on[i] = ~line_config[i].input_off;
        end
    end

    // read mux; reads have no side effect on any register
    always_comb begin
        next_rdata = RST_RDATA;
        case (req.addr)
            OFS_DRIVE_LEVEL:   next_rdata = drive_level_reg;
            OFS_DRIVE_SET:     next_rdata = drive_level_reg;
            OFS_DRIVE_CLEAR:   next_rdata = drive_level_reg;
            OFS_SAMPLED_LEVEL: next_rdata = sampled_level;
            OFS_ORIENT:        next_rdata = orientation_reg;
            OFS_ORIENT_SET:    next_rdata = orientation_reg;
            OFS_ORIENT_CLEAR:  next_rdata = orientation_reg;
            default: begin
                if (gpp_is_line_cfg(req.addr)) begin
                    // direction bit read back from the shared flip-flop
                    next_rdata = gpp_cfg_pack(orientation_reg[line_idx],
                                              line_config[line_idx]);
                end else begin
                    next_rdata = RST_RDATA;  // unmapped reads as zero
                end
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= RST_RDATA;
        end else if (req.re) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= RST_RDATA;
        end
    end

    // pins come from outside the clock domain, so two stages first
    gpp_in_sync u_in_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .pad_in_i  (pad_in_i),
        .buf_on_i  (buf_on),
        .level_o   (sampled_level)
    );

    // output stage turns level, direction and drive mode into pad controls
    gpp_pin_drive u_pin_drive (
        .clk_i          (clk_i),
        .reset_n_i      (reset_n_i),
        .level_i        (drive_level_reg),
        .dir_i          (orientation_reg),
        .cfg_i          (line_config),
        .pad_out_o      (pad_out_o),
        .pad_oe_o       (pad_oe_o),
        .pad_hi_drive_o (pad_hi_drive_o),
        .pull_up_o      (pull_up_o),
        .pull_down_o    (pull_down_o)
    );

endmodule : gpp_port
`default_nettype wire

//--- verification/gpp_port_sva.sv
// checker for the port register slave and its pad controls
`timescale 1ns/1ns
`default_nettype none
module gpp_port_chk
    import gpp_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic [GPP_ADDR_W-1:0] addr_i,
    input  wire logic [GPP_DATA_W-1:0] wdata_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    input  wire logic [GPP_DATA_W-1:0] rdata_o,
    input  wire logic [GPP_PINS-1:0]   pad_in_i,
    input  wire logic [GPP_PINS-1:0]   pad_out_o,
    input  wire logic [GPP_PINS-1:0]   pad_oe_o,
    input  wire logic [GPP_PINS-1:0]   pad_hi_drive_o,
    input  wire logic [GPP_PINS-1:0]   pull_up_o,
    input  wire logic [GPP_PINS-1:0]   pull_down_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // decoded strobes; pad_out_o trails the level register by one cycle
    wire logic set_w = we_i && addr_i == OFS_DRIVE_SET;
    wire logic clr_w = we_i && addr_i == OFS_DRIVE_CLEAR;
    wire logic lvl_w = set_w || clr_w || (we_i && addr_i == OFS_DRIVE_LEVEL);
    wire logic lvl_r = re_i && (addr_i inside {OFS_DRIVE_LEVEL, OFS_DRIVE_SET, OFS_DRIVE_CLEAR});

    rdata_idle_a: assert property (!re_i |=> rdata_o == RST_RDATA)
        else $error("read data not zero outside answer cycle");
    level_read_a: assert property (lvl_r |=> rdata_o == pad_out_o)
        else $error("level alias read differs from drive level");
    level_set_a: assert property (set_w |=> ##1 (pad_out_o & $past(wdata_i, 2)) == $past(wdata_i, 2))
        else $error("set alias did not raise written bits");
    set_keep_a: assert property (set_w |=> ##1 ((pad_out_o ^ $past(pad_out_o)) & ~$past(wdata_i, 2)) == '0)
        else $error("set alias disturbed unwritten bits");
    level_clear_a: assert property (clr_w |=> ##1 (pad_out_o & $past(wdata_i, 2)) == '0)
        else $error("clear alias did not lower written bits");
    clear_keep_a: assert property (clr_w |=> ##1 ((pad_out_o ^ $past(pad_out_o)) & ~$past(wdata_i, 2)) == '0)
        else $error("clear alias disturbed unwritten bits");
    level_hold_a: assert property (!lvl_w |=> ##1 pad_out_o == $past(pad_out_o))
        else $error("drive level changed without a level write");
    dir_clear_a: assert property (we_i && addr_i == OFS_ORIENT_CLEAR |=> ##1 (pad_oe_o & $past(wdata_i, 2)) == '0)
        else $error("cleared direction bits still drive");
endmodule : gpp_port_chk

bind gpp_port gpp_port_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_hi_drive_o(pad_hi_drive_o),
    .pull_up_o(pull_up_o), .pull_down_o(pull_down_o));
`default_nettype wire

//--- verification/gpp_pins_model.sv
// outside circuitry on the port pins
`timescale 1ns/1ns
`default_nettype none
module gpp_pins_model
    import gpp_pkg::*;
(
    input  wire logic [GPP_PINS-1:0] pad_out_i,
    input  wire logic [GPP_PINS-1:0] pad_oe_i,
    input  wire logic [GPP_PINS-1:0] pull_up_i,
    input  wire logic [GPP_PINS-1:0] pull_down_i,
    input  wire logic [GPP_PINS-1:0] ext_lvl_i,
    output logic      [GPP_PINS-1:0] pad_in_o
);
    // a driven pin reads its own level; a released one follows its pull, else the outside source
    assign pad_in_o = (pad_oe_i & pad_out_i)
                    | (~pad_oe_i & (pull_up_i | (~pull_down_i & ext_lvl_i)));
endmodule : gpp_pins_model
`default_nettype wire

//--- verification/gpp_port_tb_top.sv
// self-checking bench for the general purpose port
`timescale 1ns/1ns
`default_nettype none
module gpp_port_tb_top;
    import gpp_pkg::*;
    logic        clk_i, reset_n_i, we_i, re_i;
    logic [11:0] addr_i;
    logic [31:0] wdata_i, ext_lvl, rdata_o, pad_in_i, pad_out_o, pad_oe_o;
    logic [31:0] hi_drv, pull_up_o, pull_down_o;
    int          mismatches, compares, cycles;

    gpp_port dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .pad_hi_drive_o(hi_drv), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o));
    gpp_pins_model pins_u (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pull_up_i(pull_up_o),
        .pull_down_i(pull_down_o), .ext_lvl_i(ext_lvl), .pad_in_o(pad_in_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so look just past that edge
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // the whole run needs under a hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        reset_n_i = 1'b0;
        we_i      = 1'b0;
        re_i      = 1'b0;
        addr_i    = 12'h000;
        wdata_i   = 32'h0000_0000;
        ext_lvl   = 32'hFFFF_FFFD;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // inputs start disconnected, so the sampled word reads zero too
        for (int i = 0; i < 7; i++) rd(12'h504 + 12'(4 * i), 32'h0000_0000);
        rd(12'h704, RST_LINE_CFG);
        $display("test reset done");
        wr(OFS_DRIVE_LEVEL, 32'hA5A5_0F0F);
        rd(OFS_DRIVE_LEVEL, 32'hA5A5_0F0F);
        wr(OFS_DRIVE_SET, 32'h0000_F0F0);
        rd(OFS_DRIVE_SET, 32'hA5A5_FFFF);
        wr(OFS_DRIVE_CLEAR, 32'h8000_000F);
        rd(OFS_DRIVE_CLEAR, 32'h25A5_FFF0);
        chk(pad_out_o, 32'h25A5_FFF0);
        $display("test level done");
        wr(OFS_ORIENT_SET, 32'hFFFF_0000);
        rd(OFS_ORIENT, 32'hFFFF_0000);
        wr(OFS_ORIENT_CLEAR, 32'h0F0F_0000);
        rd(OFS_ORIENT_CLEAR, 32'hF0F0_0000);
        rd(OFS_ORIENT_SET, 32'hF0F0_0000);
        chk(pad_oe_o, 32'hF0F0_0000);
        // direction reached through the line config words as well
        wr(OFS_ORIENT, 32'h0000_0001);
        wr(12'h704, 32'h0000_0001);
        rd(OFS_ORIENT, 32'h0000_0003);
        wr(OFS_LINE_CFG_BASE, 32'h0000_0000);
        rd(OFS_ORIENT, 32'h0000_0002);
        chk(pad_oe_o, 32'h0000_0002);
        $display("test direction done");
        // pin 0 is a connected input, pin 1 a connected output at level 0
        wr(OFS_SAMPLED_LEVEL, 32'hFFFF_FFFF);
        repeat (4) @(posedge clk_i);
        rd(OFS_SAMPLED_LEVEL, 32'h0000_0001);
        wr(OFS_DRIVE_SET, 32'h0000_0002);
        ext_lvl <= 32'hFFFF_FFFC;
        repeat (6) @(posedge clk_i);
        rd(OFS_SAMPLED_LEVEL, 32'h0000_0002);
        rd(12'h000, 32'h0000_0000);
        $display("test sampled done");
        // pin 1: pull-up, drive mode 5 floats a low level and drives a high one hard
        wr(12'h704, 32'h0000_050D);
        rd(12'h704, 32'h0000_050D);
        chk(pad_oe_o, 32'h0000_0002);
        chk(hi_drv, 32'h0000_0002);
        chk(pull_up_o, 32'h0000_0002);
        chk(pull_down_o, 32'h0000_0000);
        // a low level floats, so only the pull-up holds the released pin high
        wr(OFS_DRIVE_CLEAR, 32'h0000_0002);
        repeat (4) @(posedge clk_i);
        rd(OFS_SAMPLED_LEVEL, 32'h0000_0002);
        chk(pad_oe_o, 32'h0000_0000);
        chk(hi_drv, 32'h0000_0000);
        // pin 0 pulled down outweighs a high outside source
        wr(OFS_LINE_CFG_BASE, 32'h0000_0004);
        ext_lvl <= 32'hFFFF_FFFF;
        repeat (4) @(posedge clk_i);
        rd(OFS_SAMPLED_LEVEL, 32'h0000_0002);
        chk(pull_down_o, 32'h0000_0001);
        $display("test drive mode done");
        complete_run();
    end
endmodule : gpp_port_tb_top
`default_nettype wire
